//--- pbc_params.svh
/*
  shared figures of the bus control pair: control line masks, bus commands,
  register offsets, fields, reset values and counts.
  assumes it is included by bare name wherever a figure is used.
*/
`ifndef PBC_PARAMS_SVH
`define PBC_PARAMS_SVH
`define PBC_C_FRAME 5'h01
`define PBC_C_IRDY 5'h02
`define PBC_C_TRDY 5'h04
`define PBC_C_DEVSEL 5'h08
`define PBC_C_STOP 5'h10
`define PBC_BUSCMD_MEM_RD 4'h6
`define PBC_BUSCMD_MEM_WR 4'h7
`define PBC_BUSCMD_CFG_RD 4'ha
`define PBC_BUSCMD_CFG_WR 4'hb
`define PBC_CFG_CMDCTL_OFF 8'h04
`define PBC_CMDCTL_RST 16'h0000
`define PBC_CMDCTL_PERR_EN 6
`define PBC_CMDCTL_SERR_EN 8
`define PBC_DEVSEL_TMO 3'h5
`define PBC_A_CTRL 12'h000
`define PBC_A_ADDR 12'h004
`define PBC_A_WDATA 12'h008
`define PBC_A_RDATA 12'h00c
`define PBC_A_STATUS 12'h010
`define PBC_A_IRQ_STAT 12'h014
`define PBC_A_IRQ_MASK 12'h018
`define PBC_A_MBOX 12'h01c
`define PBC_CTRL_GO 0
`define PBC_CTRL_WR 1
`define PBC_CTRL_CFG 2
`define PBC_CTRL_PARK 3
`define PBC_CTRL_RST 8'hf0
`define PBC_IRQ_DONE 0
`define PBC_IRQ_ABORT 1
`define PBC_IRQ_PERR 2
`define PBC_IRQ_SERR 3
`define PBC_IRQ_MBOX 4
`endif

//--- pbc_pkg.sv
/*
  types and helpers shared by both ends of the bus control pair.
  assumes nothing beyond a SystemVerilog compiler.
*/
package pbc_pkg;
  typedef logic [31:0] pbc_word_t;
  typedef logic [3:0] pbc_be_t;
  typedef logic [15:0] pbc_cmdreg_t;
  typedef logic [11:0] pbc_apb_addr_t;
  typedef logic [4:0] pbc_irq_t;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_M_ADDR = 6'h02,
    ST_M_DATA = 6'h04,
    ST_M_END = 6'h08,
    ST_T_DATA = 6'h10,
    ST_T_END = 6'h20
  } pbc_st_t;

  // read and write forms of a command differ only in bit 0
  function automatic logic pbc_is_cmd(input pbc_be_t c, input pbc_be_t rd);
    return c[3:1] == rd[3:1];
  endfunction

  // byte lane n of the word follows enable n (active high)
  function automatic pbc_word_t pbc_merge(input pbc_word_t old, input pbc_word_t nw,
                                          input pbc_be_t en);
    pbc_word_t r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (en[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction
endpackage

//--- pbc_bus_if.sv
/*
  the shared bus between the device end and the host end.
  each party drives its own output and enable; the wired level is
  resolved here, control lines pulled high when nobody drives.
*/
interface pbc_bus_if;
  logic [4:0] d_ctl_o, d_ctl_oe, h_ctl_o, h_ctl_oe, ctl_n;
  logic [31:0] d_ad_o, h_ad_o, ad;
  logic [3:0] d_cbe_o, h_cbe_o, cbe;
  logic d_ad_oe, h_ad_oe, d_cbe_oe, h_cbe_oe;
  logic d_par_o, d_par_oe, h_par_o, h_par_oe, par;
  logic d_perr_o, d_perr_oe, perr_n;
  logic d_serr_n, req_n, gnt_n, idsel;

  assign ctl_n = (d_ctl_oe & d_ctl_o) | (h_ctl_oe & h_ctl_o) | ~(d_ctl_oe | h_ctl_oe);
  assign ad = d_ad_oe ? d_ad_o : (h_ad_oe ? h_ad_o : '0);
  assign cbe = d_cbe_oe ? d_cbe_o : (h_cbe_oe ? h_cbe_o : '1);
  assign par = d_par_oe ? d_par_o : (h_par_oe & h_par_o);
  assign perr_n = !d_perr_oe || d_perr_o;

  modport dev (
    output d_ctl_o, d_ctl_oe, d_ad_o, d_ad_oe, d_cbe_o, d_cbe_oe,
    output d_par_o, d_par_oe, d_perr_o, d_perr_oe, d_serr_n, req_n,
    input ctl_n, ad, cbe, par, gnt_n, idsel
  );
  modport hst (
    output h_ctl_o, h_ctl_oe, h_ad_o, h_ad_oe, h_cbe_o, h_cbe_oe,
    output h_par_o, h_par_oe, gnt_n, idsel,
    input ctl_n, ad, cbe, par, perr_n, d_serr_n, req_n
  );
endinterface

//--- pbc_parity.sv
/*
  even parity over a set of bus lines, registered one clock later.
  assumes the lines are steady on the clock of the caller.
*/
module pbc_parity #(
  parameter int W = 36
) (
  input logic pclk,
  input logic presetn,
  input logic [W-1:0] bits,
  output logic par_q
);
  import pbc_pkg::*;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      par_q <= 1'b0;
    end else begin
      par_q <= ^bits;
    end
  end
endmodule

//--- pbc_device_end.sv
/*
  device end of the bus: configuration target holding the command/control
  register, single-phase memory initiator, parity and system error
  reporting, and the switch enable for a card in the socket.
  assumes the host end drives grant, idsel and its own bus lines on pclk;
  the card detect pin is asynchronous.
*/
`include "pbc_params.svh"

// Function
// - claim own configuration cycles with device select
// - initiator aborts when no device select arrives
// - frame opens transaction, released on final phase
// - grant may come unrequested; park on it
// - configuration responds only with idsel asserted
// - phase completes when both readies sampled
// - initiator ready and target ready signal readiness
// - parity error flagged only when enabled
// - system error pulsed when enabled
// - socket address parity error also pulses it
// - target stop ends transfer; initiator obeys
// - request asserted while initiator work pends
// - switch enable follows card detect
// - even parity driven one clock later, checked
// - command then byte enables per lane
module pbc_device_end #(
  parameter logic [2:0] TMO = `PBC_DEVSEL_TMO
) (
  input logic pclk,
  input logic presetn,
  pbc_bus_if.dev bus,
  input logic mst_go,
  input logic mst_wr,
  input pbc_pkg::pbc_word_t mst_addr,
  input pbc_pkg::pbc_word_t mst_wdata,
  input pbc_pkg::pbc_be_t mst_be,
  output logic mst_busy,
  output logic mst_done,
  output logic mst_abort,
  output pbc_pkg::pbc_word_t mst_rdata,
  input logic sys_err,
  input logic cb_addr_perr,
  input logic usb_card_pin,
  output logic usb_sw_en,
  output pbc_pkg::pbc_cmdreg_t cmd_reg
);
  import pbc_pkg::*;

  pbc_st_t st_q;
  logic frame, irdy, trdy, devsel, stop, gnt, bus_idle, hit;
  logic fr_d_q, wr_q, treg_q, tgt_wr_q, chk_q, usb_s1_q, par_bad;
  logic ev_sys, ev_cb, serr_take;
  pbc_word_t addr_q, wdata_q;
  pbc_be_t be_q;
  logic [2:0] tmo_q;
  logic [2:0] serr_cnt_q;

  assign frame = (bus.ctl_n & `PBC_C_FRAME) == '0;
  assign irdy = (bus.ctl_n & `PBC_C_IRDY) == '0;
  assign trdy = (bus.ctl_n & `PBC_C_TRDY) == '0;
  assign devsel = (bus.ctl_n & `PBC_C_DEVSEL) == '0;
  assign stop = (bus.ctl_n & `PBC_C_STOP) == '0;
  assign gnt = !bus.gnt_n;
  assign bus_idle = !frame && !irdy;
  // first clock of frame, config command, type 0, our select line
  assign hit = frame && !fr_d_q && bus.idsel && bus.ad[1:0] == 2'b00 &&
               pbc_is_cmd(bus.cbe, `PBC_BUSCMD_CFG_RD);
  assign par_bad = chk_q && (bus.par != bus.d_par_o);

  // parity of last clock's lines: drives par and serves the check
  pbc_parity #(.W(36)) u_par (
    .pclk(pclk),
    .presetn(presetn),
    .bits({bus.cbe, bus.ad}),
    .par_q(bus.d_par_o)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fr_d_q <= 1'b0;
      bus.d_par_oe <= 1'b0;
    end else begin
      fr_d_q <= frame;
      bus.d_par_oe <= bus.d_ad_oe;
    end
  end

  // initiator request capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q <= 1'b0;
      addr_q <= '0;
      wdata_q <= '0;
      be_q <= '0;
    end else if (mst_go && !mst_busy) begin
      wr_q <= mst_wr;
      addr_q <= mst_addr;
      wdata_q <= mst_wdata;
      be_q <= mst_be;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_IDLE;
      bus.d_ctl_o <= '1;
      bus.d_ctl_oe <= '0;
      bus.d_ad_o <= '0;
      bus.d_ad_oe <= 1'b0;
      bus.d_cbe_o <= '0;
      bus.d_cbe_oe <= 1'b0;
      bus.req_n <= 1'b1;
      mst_busy <= 1'b0;
      mst_done <= 1'b0;
      mst_abort <= 1'b0;
      mst_rdata <= '0;
      tmo_q <= '0;
      treg_q <= 1'b0;
      tgt_wr_q <= 1'b0;
      chk_q <= 1'b0;
    end else begin
      mst_done <= 1'b0;
      mst_abort <= 1'b0;
      chk_q <= 1'b0;
      if (mst_go && !mst_busy) begin
        mst_busy <= 1'b1;
      end
      unique case (st_q)
        ST_IDLE: begin
          bus.req_n <= !mst_busy;
          bus.d_ad_o <= '0;
          bus.d_cbe_o <= '0;
          bus.d_ad_oe <= gnt && bus_idle && !mst_busy;
          bus.d_cbe_oe <= gnt && bus_idle && !mst_busy;
          if (hit) begin
            st_q <= ST_T_DATA;
            tgt_wr_q <= bus.cbe[0];
            treg_q <= bus.ad[7:0] == `PBC_CFG_CMDCTL_OFF;
            // claim, ready at once, disconnect after one phase
            bus.d_ctl_oe <= `PBC_C_DEVSEL | `PBC_C_TRDY | `PBC_C_STOP;
            bus.d_ctl_o <= '0;
            bus.d_ad_o <= (bus.ad[7:0] == `PBC_CFG_CMDCTL_OFF) ? {16'h0000, cmd_reg} : '0;
            bus.d_ad_oe <= !bus.cbe[0];
            bus.d_cbe_oe <= 1'b0;
          end else if (mst_busy && gnt && bus_idle) begin
            st_q <= ST_M_ADDR;
            bus.req_n <= 1'b1;
            bus.d_ctl_oe <= `PBC_C_FRAME;
            bus.d_ctl_o <= '0;
            bus.d_ad_o <= addr_q;
            bus.d_ad_oe <= 1'b1;
            bus.d_cbe_o <= wr_q ? `PBC_BUSCMD_MEM_WR : `PBC_BUSCMD_MEM_RD;
            bus.d_cbe_oe <= 1'b1;
          end
        end
        ST_M_ADDR: begin
          st_q <= ST_M_DATA;
          bus.d_ctl_oe <= `PBC_C_FRAME | `PBC_C_IRDY;
          bus.d_ctl_o <= `PBC_C_FRAME;
          bus.d_ad_o <= wdata_q;
          bus.d_ad_oe <= wr_q;
          bus.d_cbe_o <= ~be_q;
          tmo_q <= '0;
        end
        ST_M_DATA: begin
          if ((irdy && trdy) || stop || (!devsel && tmo_q == TMO - 3'h1)) begin
            st_q <= ST_M_END;
            mst_busy <= 1'b0;
            bus.d_ctl_o <= '1;
            bus.d_ctl_oe <= `PBC_C_IRDY;
            bus.d_ad_oe <= 1'b0;
            bus.d_cbe_oe <= 1'b0;
          end else if (!devsel) begin
            tmo_q <= tmo_q + 3'h1;
          end
          if (irdy && trdy) begin
            mst_done <= 1'b1;
            mst_rdata <= bus.ad;
            chk_q <= !wr_q;
          end else if (stop || (!devsel && tmo_q == TMO - 3'h1)) begin
            mst_abort <= 1'b1;
          end
        end
        ST_M_END: begin
          st_q <= ST_IDLE;
          bus.d_ctl_oe <= '0;
        end
        ST_T_DATA: begin
          if (irdy) begin
            st_q <= ST_T_END;
            bus.d_ctl_o <= '1;
            bus.d_ad_oe <= 1'b0;
            chk_q <= tgt_wr_q;
          end
        end
        ST_T_END: begin
          st_q <= ST_IDLE;
          bus.d_ctl_oe <= '0;
        end
      endcase
    end
  end

  // command/control register, written by a configuration write phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_reg <= `PBC_CMDCTL_RST;
    end else if (st_q == ST_T_DATA && irdy && tgt_wr_q && treg_q) begin
      cmd_reg <= 16'(pbc_merge({16'h0000, cmd_reg}, bus.ad, ~bus.cbe));
    end
  end

  // parity error: low one clock, driven high one more, then released
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus.d_perr_o <= 1'b1;
      bus.d_perr_oe <= 1'b0;
    end else if (par_bad && cmd_reg[`PBC_CMDCTL_PERR_EN]) begin
      bus.d_perr_o <= 1'b0;
      bus.d_perr_oe <= 1'b1;
    end else if (!bus.d_perr_o) begin
      bus.d_perr_o <= 1'b1;
    end else begin
      bus.d_perr_oe <= 1'b0;
    end
  end

  // system errors queue up; each pulse is followed by a high clock
  assign ev_sys = sys_err && cmd_reg[`PBC_CMDCTL_SERR_EN];
  assign ev_cb = cb_addr_perr && cmd_reg[`PBC_CMDCTL_SERR_EN];
  assign serr_take = bus.d_serr_n && serr_cnt_q != 3'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serr_cnt_q <= '0;
      bus.d_serr_n <= 1'b1;
    end else begin
      bus.d_serr_n <= !serr_take;
      serr_cnt_q <= serr_cnt_q + {2'b00, ev_sys} + {2'b00, ev_cb} - {2'b00, serr_take};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usb_s1_q <= 1'b0;
      usb_sw_en <= 1'b0;
    end else begin
      usb_s1_q <= usb_card_pin;
      usb_sw_en <= usb_s1_q;
    end
  end
endmodule

//--- pbc_host_end.sv
/*
  host end of the bus: arbiter with parking, single-phase initiator driven
  from APB registers, memory target with a mailbox word, error interrupts.
  assumes the device end shares pclk; APB master on the same clock.
*/
`include "pbc_params.svh"

module pbc_host_end #(
  parameter logic [2:0] TMO = `PBC_DEVSEL_TMO
) (
  input logic pclk,
  input logic presetn,
  pbc_bus_if.hst bus,
  input pbc_pkg::pbc_apb_addr_t paddr,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input pbc_pkg::pbc_word_t pwdata,
  output pbc_pkg::pbc_word_t prdata,
  output logic pready,
  output logic pslverr,
  output logic irq
);
  import pbc_pkg::*;

  pbc_st_t st_q;
  logic frame, irdy, trdy, devsel, stop, bus_idle, hit, wr_en, known;
  logic fr_d_q, g_d_q, busy_q, tgt_wr_q, chk_q, done_q, abort_q, mbox_ev_q;
  logic [7:1] ctrl_q;
  logic [2:0] tmo_q;
  pbc_word_t addr_q, wdata_q, rdata_q, mbox_q, rd_mux;
  pbc_irq_t stat_q, mask_q, ev;

  assign frame = (bus.ctl_n & `PBC_C_FRAME) == '0;
  assign irdy = (bus.ctl_n & `PBC_C_IRDY) == '0;
  assign trdy = (bus.ctl_n & `PBC_C_TRDY) == '0;
  assign devsel = (bus.ctl_n & `PBC_C_DEVSEL) == '0;
  assign stop = (bus.ctl_n & `PBC_C_STOP) == '0;
  assign bus_idle = !frame && !irdy;
  assign hit = frame && !fr_d_q && pbc_is_cmd(bus.cbe, `PBC_BUSCMD_MEM_RD);
  assign wr_en = psel && penable && pready && pwrite;

  pbc_parity #(.W(36)) u_par (
    .pclk(pclk),
    .presetn(presetn),
    .bits({bus.cbe, bus.ad}),
    .par_q(bus.h_par_o)
  );

  // arbiter: while busy_q is clear, device gets the bus when asking, or parked when allowed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus.gnt_n <= 1'b1;
      g_d_q <= 1'b1;
      fr_d_q <= 1'b0;
      bus.h_par_oe <= 1'b0;
    end else begin
      bus.gnt_n <= busy_q || (bus.req_n && !ctrl_q[`PBC_CTRL_PARK]);
      g_d_q <= bus.gnt_n;
      fr_d_q <= frame;
      bus.h_par_oe <= bus.h_ad_oe;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_IDLE;
      bus.h_ctl_o <= '1;
      bus.h_ctl_oe <= '0;
      bus.h_ad_o <= '0;
      bus.h_ad_oe <= 1'b0;
      bus.h_cbe_o <= '0;
      bus.h_cbe_oe <= 1'b0;
      bus.idsel <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      abort_q <= 1'b0;
      chk_q <= 1'b0;
      tmo_q <= '0;
      tgt_wr_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      done_q <= 1'b0;
      abort_q <= 1'b0;
      chk_q <= 1'b0;
      if (wr_en && paddr == `PBC_A_CTRL && pwdata[`PBC_CTRL_GO]) begin
        busy_q <= 1'b1;
      end
      unique case (st_q)
        ST_IDLE: begin
          if (hit) begin
            st_q <= ST_T_DATA;
            tgt_wr_q <= bus.cbe[0];
            bus.h_ctl_oe <= `PBC_C_DEVSEL | `PBC_C_TRDY | `PBC_C_STOP;
            bus.h_ctl_o <= '0;
            bus.h_ad_o <= mbox_q;
            bus.h_ad_oe <= !bus.cbe[0];
          end else if (busy_q && bus.gnt_n && g_d_q && bus_idle) begin
            st_q <= ST_M_ADDR;
            bus.h_ctl_oe <= `PBC_C_FRAME;
            bus.h_ctl_o <= '0;
            bus.h_ad_o <= addr_q;
            bus.h_ad_oe <= 1'b1;
            bus.idsel <= ctrl_q[`PBC_CTRL_CFG];
            bus.h_cbe_o <= ctrl_q[`PBC_CTRL_CFG] ?
                           {3'b101, ctrl_q[`PBC_CTRL_WR]} : {3'b011, ctrl_q[`PBC_CTRL_WR]};
            bus.h_cbe_oe <= 1'b1;
          end
        end
        ST_M_ADDR: begin
          st_q <= ST_M_DATA;
          bus.idsel <= 1'b0;
          bus.h_ctl_oe <= `PBC_C_FRAME | `PBC_C_IRDY;
          bus.h_ctl_o <= `PBC_C_FRAME;
          bus.h_ad_o <= wdata_q;
          bus.h_ad_oe <= ctrl_q[`PBC_CTRL_WR];
          bus.h_cbe_o <= ~ctrl_q[7:4];
          tmo_q <= '0;
        end
        ST_M_DATA: begin
          if ((irdy && trdy) || stop || (!devsel && tmo_q == TMO - 3'h1)) begin
            st_q <= ST_M_END;
            busy_q <= 1'b0;
            bus.h_ctl_o <= '1;
            bus.h_ctl_oe <= `PBC_C_IRDY;
            bus.h_ad_oe <= 1'b0;
            bus.h_cbe_oe <= 1'b0;
          end else if (!devsel) begin
            tmo_q <= tmo_q + 3'h1;
          end
          if (irdy && trdy) begin
            done_q <= 1'b1;
            rdata_q <= bus.ad;
            chk_q <= !ctrl_q[`PBC_CTRL_WR];
          end else if (stop || (!devsel && tmo_q == TMO - 3'h1)) begin
            abort_q <= 1'b1;
          end
        end
        ST_T_DATA: begin
          if (irdy) begin
            st_q <= ST_T_END;
            bus.h_ctl_o <= '1;
            bus.h_ad_oe <= 1'b0;
            chk_q <= tgt_wr_q;
          end
        end
        ST_M_END, ST_T_END: begin
          st_q <= ST_IDLE;
          bus.h_ctl_oe <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // reset byte includes the busy bit, which is not stored
      ctrl_q <= 7'(`PBC_CTRL_RST >> 1);
      addr_q <= '0;
      wdata_q <= '0;
      mask_q <= '0;
      mbox_q <= '0;
      mbox_ev_q <= 1'b0;
    end else begin
      mbox_ev_q <= st_q == ST_T_DATA && irdy && tgt_wr_q;
      if (st_q == ST_T_DATA && irdy && tgt_wr_q) begin
        mbox_q <= pbc_merge(mbox_q, bus.ad, ~bus.cbe);
      end else if (wr_en && paddr == `PBC_A_MBOX) begin
        mbox_q <= pwdata;
      end
      if (wr_en && paddr == `PBC_A_CTRL && !busy_q) begin
        ctrl_q <= pwdata[7:1];
      end
      if (wr_en && paddr == `PBC_A_ADDR) begin
        addr_q <= pwdata;
      end
      if (wr_en && paddr == `PBC_A_WDATA) begin
        wdata_q <= pwdata;
      end
      if (wr_en && paddr == `PBC_A_IRQ_MASK) begin
        mask_q <= pwdata[4:0];
      end
    end
  end

  // sticky events; a new event wins over a write-one clear
  always_comb begin
    ev = '0;
    ev[`PBC_IRQ_DONE] = done_q;
    ev[`PBC_IRQ_ABORT] = abort_q;
    ev[`PBC_IRQ_PERR] = (chk_q && bus.par != bus.h_par_o) || !bus.perr_n;
    ev[`PBC_IRQ_SERR] = !bus.d_serr_n;
    ev[`PBC_IRQ_MBOX] = mbox_ev_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= '0;
      irq <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~((wr_en && paddr == `PBC_A_IRQ_STAT) ? pwdata[4:0] : '0)) | ev;
      irq <= |(stat_q & mask_q);
    end
  end

  always_comb begin
    known = 1'b1;
    rd_mux = '0;
    unique case (paddr)
      `PBC_A_CTRL: rd_mux = {24'h000000, ctrl_q, busy_q};
      `PBC_A_ADDR: rd_mux = addr_q;
      `PBC_A_WDATA: rd_mux = wdata_q;
      `PBC_A_RDATA: rd_mux = rdata_q;
      `PBC_A_STATUS: rd_mux = {29'h0, !bus.gnt_n, !bus.req_n, busy_q};
      `PBC_A_IRQ_STAT: rd_mux = {27'h0, stat_q};
      `PBC_A_IRQ_MASK: rd_mux = {27'h0, mask_q};
      `PBC_A_MBOX: rd_mux = mbox_q;
      default: known = 1'b0;
    endcase
  end

  // one wait-free access: answer registered at the end of setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !known;
      prdata <= (psel && !penable && !pwrite) ? rd_mux : '0;
    end
  end
endmodule

//--- pbc_bus_assertions.sv
/*
  checker on the shared bus lines of the device and host ends.
  assumes it sits beside the bus interface, all lines on pclk.
*/
module pbc_bus_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [4:0] ctl_n,
  input wire logic [4:0] d_ctl_oe,
  input wire logic [31:0] ad,
  input wire logic [3:0] cbe,
  input wire logic d_ad_oe,
  input wire logic par,
  input wire logic perr_n,
  input wire logic d_serr_n,
  input wire logic gnt_n,
  input wire logic idsel
);
  localparam int TMO_MAX = 7;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_frame_one_clk: assert property ($fell(ctl_n[0]) |=> ctl_n[0] && !ctl_n[1])
    else $error("frame not one clock");
  a_claim_cfg_cycle: assert property ($fell(ctl_n[0]) && idsel && cbe[3:1] == 3'h5
    && ad[1:0] == 2'h0 |=> !ctl_n[3] && d_ctl_oe[3]) else $error("cfg cycle not claimed");
  a_cfg_needs_idsel: assert property ($fell(ctl_n[0]) && !idsel |=> !d_ctl_oe[3])
    else $error("claimed without idsel");
  a_target_trio: assert property ($fell(ctl_n[3]) |-> !ctl_n[2] && !ctl_n[4])
    else $error("devsel without trdy and stop");
  a_phase_done: assert property (!ctl_n[1] && !ctl_n[2] |=> ctl_n[1] && ctl_n[2])
    else $error("phase not ended");
  a_abort_bound: assert property ($fell(ctl_n[1]) |-> ##[1:TMO_MAX] ctl_n[1])
    else $error("no abort in time");
  a_start_granted: assert property ($fell(ctl_n[0]) && d_ctl_oe[0] |-> !$past(gnt_n))
    else $error("start without grant");
  a_par_even: assert property (d_ad_oe |=> par == ^{$past(ad), $past(cbe)})
    else $error("bad parity");
  a_perr_one_clk: assert property ($fell(perr_n) |=> perr_n)
    else $error("perr too long");
  a_serr_one_clk: assert property ($fell(d_serr_n) |=> d_serr_n)
    else $error("serr too long");
  c_dev_claim: cover property ($fell(ctl_n[3]) && d_ctl_oe[3]);
  c_dev_start: cover property ($fell(ctl_n[0]) && d_ctl_oe[0]);
  c_serr: cover property ($fell(d_serr_n));
endmodule

//--- test_pci_bus_control_signalling.sv
/*
  self-checking bench: both ends joined by the bus interface, host end
  reached over apb, device user side driven directly.
  assumes the shared header and package are compiled first.
*/
`include "pbc_params.svh"
module test_pci_bus_control_signalling;
  timeunit 1ns;
  timeprecision 1ps;
  import pbc_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  pbc_apb_addr_t paddr = '0;
  pbc_word_t pwdata = '0, prdata, rd, mst_rdata, mst_addr = '0, mst_wdata = '0;
  logic pready, pslverr, err, irq, mst_busy, mst_done, mst_abort, usb_sw_en;
  logic mst_go = 0, mst_wr = 0, sys_err = 0, cb_addr_perr = 0, usb_card_pin = 0;
  pbc_be_t mst_be = '0, be;
  pbc_cmdreg_t cmd_reg;
  int bad_count = 0, total_checks = 0, cyc = 0, mbox = 0, cmdm = 0, n, w;
  always #4 pclk = ~pclk;
  pbc_bus_if pbc_bus_if_i ();
  pbc_device_end #(.TMO(`PBC_DEVSEL_TMO)) pbc_device_end_i (.pclk(pclk), .presetn(presetn),
    .bus(pbc_bus_if_i.dev), .mst_go(mst_go), .mst_wr(mst_wr), .mst_addr(mst_addr),
    .mst_wdata(mst_wdata), .mst_be(mst_be), .mst_busy(mst_busy), .mst_done(mst_done),
    .mst_abort(mst_abort), .mst_rdata(mst_rdata), .sys_err(sys_err),
    .cb_addr_perr(cb_addr_perr), .usb_card_pin(usb_card_pin), .usb_sw_en(usb_sw_en),
    .cmd_reg(cmd_reg));
  pbc_host_end #(.TMO(`PBC_DEVSEL_TMO)) pbc_host_end_i (.pclk(pclk), .presetn(presetn),
    .bus(pbc_bus_if_i.hst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));
  pbc_bus_assertions pbc_bus_assertions_i (.pclk(pclk), .presetn(presetn),
    .ctl_n(pbc_bus_if_i.ctl_n), .d_ctl_oe(pbc_bus_if_i.d_ctl_oe), .ad(pbc_bus_if_i.ad),
    .cbe(pbc_bus_if_i.cbe), .d_ad_oe(pbc_bus_if_i.d_ad_oe), .par(pbc_bus_if_i.par),
    .perr_n(pbc_bus_if_i.perr_n), .d_serr_n(pbc_bus_if_i.d_serr_n),
    .gnt_n(pbc_bus_if_i.gnt_n), .idsel(pbc_bus_if_i.idsel));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      complete_run();
    end
  end

  task automatic check(input pbc_word_t got, input pbc_word_t exp, input string what);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input pbc_apb_addr_t a, input pbc_word_t d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // host transfer through its registers, then poll busy
  task automatic host_op(input pbc_word_t ctrl, input pbc_word_t a, input pbc_word_t d);
    apb(1'b1, `PBC_A_ADDR, a);
    apb(1'b1, `PBC_A_WDATA, d);
    apb(1'b1, `PBC_A_CTRL, ctrl);
    n = 0;
    do begin
      apb(1'b0, `PBC_A_STATUS, '0);
      n++;
    end while (rd[0] !== 1'b0 && n < 40);
    check(rd[0], 1'b0, "host idle");
  endtask

  task automatic dev_op(input logic wr, input pbc_word_t d, input pbc_be_t b);
    mst_go <= 1'b1;
    mst_wr <= wr;
    mst_addr <= $urandom;
    mst_wdata <= d;
    mst_be <= b;
    @(posedge pclk);
    mst_go <= 1'b0;
    n = 0;
    while (mst_done !== 1'b1 && n < 60) begin
      @(posedge pclk);
      n++;
    end
  endtask

  task automatic serr_pulse(input bit cb);
    int lows;
    lows = 0;
    if (cb)
      cb_addr_perr <= 1'b1;
    else
      sys_err <= 1'b1;
    @(posedge pclk);
    sys_err <= 1'b0;
    cb_addr_perr <= 1'b0;
    repeat (8) begin
      @(posedge pclk);
      lows += (pbc_bus_if_i.d_serr_n === 1'b0);
    end
    check(lows, cmdm[8], "serr pulse count");
  endtask

  initial begin
    void'($urandom(32'hba2487c0));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `PBC_A_CTRL, '0);
    check(rd, 32'hf0, "ctrl reset");
    check({16'h0, cmd_reg}, `PBC_CMDCTL_RST, "cmd reset");
    // config writes: all lanes, then lane 0 only
    w = $urandom | 32'h140;
    cmdm = w & 32'hffff;
    host_op(32'hf7, 32'h4, w);
    check({16'h0, cmd_reg}, cmdm, "cfg write");
    w = $urandom | 32'h40;
    cmdm = (cmdm & 32'hff00) | (w & 32'hff);
    host_op(32'h17, 32'h4, w);
    check({16'h0, cmd_reg}, cmdm, "cfg lane write");
    host_op(32'hf5, 32'h4, '0);
    apb(1'b0, `PBC_A_RDATA, '0);
    check(rd & 32'hffff, cmdm, "cfg read");
    apb(1'b0, `PBC_A_IRQ_STAT, '0);
    check(rd[0], 1'b1, "done flag");
    apb(1'b1, `PBC_A_IRQ_STAT, 32'h1f);
    host_op(32'hf5, 32'h5, '0);
    apb(1'b0, `PBC_A_IRQ_STAT, '0);
    check(rd[1:0], 2'h2, "unclaimed abort");
    $display("config tests done");
    for (int k = 0; k < 4; k++) begin
      w = $urandom;
      be = (k == 0) ? 4'hf : 4'($urandom);
      for (int i = 0; i < 4; i++)
        if (be[i]) mbox[i*8 +: 8] = w[i*8 +: 8];
      dev_op(1'b1, w, be);
      check(mst_done, 1'b1, "dev write done");
      dev_op(1'b0, '0, 4'hf);
      check(mst_rdata, mbox, "dev read");
      check({mst_busy, mst_abort}, 2'b00, "dev idle");
      apb(1'b0, `PBC_A_MBOX, '0);
      check(rd, mbox, "mailbox");
    end
    apb(1'b0, `PBC_A_IRQ_STAT, '0);
    check(rd[4], 1'b1, "mailbox flag");
    check(rd[2], 1'b0, "no parity error");
    // park the grant on the device, then start a read with no request
    apb(1'b1, `PBC_A_CTRL, 32'hf8);
    apb(1'b0, `PBC_A_STATUS, '0);
    check(rd[2:1], 2'h2, "parked grant");
    dev_op(1'b0, '0, 4'hf);
    check(mst_rdata, mbox, "parked read");
    $display("device initiator tests done");
    apb(1'b1, `PBC_A_IRQ_STAT, 32'h1f);
    apb(1'b1, `PBC_A_IRQ_MASK, 32'h8);
    serr_pulse(1'b0);
    check(irq, 1'b1, "serr irq");
    apb(1'b1, `PBC_A_IRQ_STAT, 32'h8);
    @(posedge pclk);
    check(irq, 1'b0, "irq cleared");
    serr_pulse(1'b1);
    w = $urandom & 32'hfeff;
    cmdm = (cmdm & 32'hff) | (w & 32'hff00);
    host_op(32'h27, 32'h4, w);
    serr_pulse(1'b0);
    serr_pulse(1'b1);
    $display("system error tests done");
    usb_card_pin <= 1'b1;
    repeat (3) @(posedge pclk);
    check(usb_sw_en, 1'b1, "switch on");
    usb_card_pin <= 1'b0;
    repeat (3) @(posedge pclk);
    check(usb_sw_en, 1'b0, "switch off");
    apb(1'b0, 12'h020, '0);
    check(err, 1'b1, "unmapped error");
    check(rd, '0, "unmapped data");
    $display("misc tests done");
    complete_run();
  end
endmodule
